// file: hw/adma_pkg.sv
package adma_pkg;
    localparam int ADDR_W = 16;
    localparam int CNT_W = 16;
    localparam int MEM_AW = 17;
    localparam int PIPES = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = 34;
    localparam int SAMPLE_W = 8;
    localparam int WORD_W = 16;
    localparam int SWEEP_W = 8;
    localparam int HOST_MA_W = 18;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DEST = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_STEP = 8'h0C;
    localparam logic [7:0] OFS_STROBE = 8'h10;
    localparam logic [7:0] OFS_SERIAL = 8'h14;
    localparam logic [7:0] OFS_SWEEP = 8'h18;
    localparam logic [7:0] OFS_MEMADDR = 8'h1C;
    localparam logic [7:0] OFS_MEMDATA = 8'h20;

    // field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_ADDRHI_BIT = 1;
    localparam int STAT_MODE_BIT = 4;
    localparam int SER_DATA_BIT = 0;
    localparam int SER_CLK_BIT = 1;
    localparam int SER_IN_BIT = 2;
    localparam int MA_CHAN_BIT = 17;

    // reset values
    localparam logic [ADDR_W-1:0] RST_DEST = 16'h0000;
    localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
    localparam logic [ADDR_W-1:0] RST_STEP = 16'h0001;
    localparam logic [PIPES-1:0] RST_STROBE = 4'h0;

    // wait cycles of a sweep or sample-memory access
    localparam logic [1:0] EXT_WAIT = 2'h2;

    typedef enum logic [0:0] {ST_PROGRAM, ST_TRANSFER} adma_state_t;

    function automatic logic [WORD_W-1:0] adma_widen(input logic [SAMPLE_W-1:0] s);
        adma_widen = {8'h00, s};
    endfunction : adma_widen
endpackage : adma_pkg

// file: hw/adma_fifo.sv
`timescale 1ns/1ps
module adma_fifo #(
    parameter int W = 34,
    parameter int DEPTH = 8
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic in_valid, // write request
    output logic in_ready, // not full
    input wire logic [W-1:0] in_data, // write word
    output logic out_valid, // not empty
    input wire logic out_ready, // read accept
    output logic [W-1:0] out_data // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    always_comb
    begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        nxt_wp = push ? AW'(wp_ff + 1'b1) : wp_ff;
        nxt_rp = pop ? AW'(rp_ff + 1'b1) : rp_ff;
        nxt_cnt = (AW+1)'(cnt_ff + (AW+1)'(push) - (AW+1)'(pop));
        in_ready = cnt_ff != (AW+1)'(DEPTH);
        out_valid = cnt_ff != '0;
        out_data = mem_ff[rp_ff];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge pclk)
    begin
        if (push)
            mem_ff[wp_ff] <= in_data;
    end
endmodule : adma_fifo

// file: hw/adma_engine.sv
// Overview of operation
// RULE1: destination address register, host or engine loaded
// RULE2: host loads count; engine moves that many
// RULE3: add step to address after each transfer
// RULE4: strobe select picks asserted demux strobes
// RULE5: mode low is program, high transfer
// RULE6: host configures only in program mode
// RULE7: start command raises mode, begins transfer
// RULE8: dual channel uses pipes 1+3 or 2+4
// RULE9: widen each 8-bit sample to 16 bits
// RULE10: single channel leaves other memory untouched
// RULE11: two channel memories written concurrently
// RULE12: host memory access only in program mode
// RULE13: strobe demux, pass sample to memory
// RULE14: host-driven serial loop data and clock
// RULE15: sweep chip select on host sweep access
// RULE16: count zero stops strobes, mode low
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module adma_engine
    import adma_pkg::*;
(
    input wire logic pclk, // 50 MHz clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output logic transfer_mode_select, // high in transfer mode
    output logic [PIPES-1:0] demux_strobe, // acquisition strobes, pipes 1..4
    input wire logic [31:0] pipe_sample, // pipe n byte at [8n-1 -: 8]
    output logic mem1_en, // channel 1 memory enable
    output logic mem1_we, // channel 1 write
    output logic [MEM_AW-1:0] mem1_addr, // channel 1 word address
    output logic [WORD_W-1:0] mem1_wdata, // channel 1 write data
    input wire logic [WORD_W-1:0] mem1_rdata, // channel 1 read data
    output logic mem2_en, // channel 2 memory enable
    output logic mem2_we, // channel 2 write
    output logic [MEM_AW-1:0] mem2_addr, // channel 2 word address
    output logic [WORD_W-1:0] mem2_wdata, // channel 2 write data
    input wire logic [WORD_W-1:0] mem2_rdata, // channel 2 read data
    input wire logic mem_ready, // memories accept engine writes
    output logic serial_data, // serial loop data
    output logic serial_clk, // serial loop clock
    input wire logic serial_data_in, // serial loop return
    output logic sweep_cs, // sweep controller chip select
    output logic sweep_we, // sweep controller write
    output logic [SWEEP_W-1:0] sweep_wdata, // sweep controller write data
    input wire logic [SWEEP_W-1:0] sweep_rdata // sweep controller read data
);
    adma_state_t state_ff, nxt_state;
    logic [ADDR_W-1:0] dest_ff, nxt_dest, step_ff, nxt_step;
    logic [CNT_W-1:0] count_ff, nxt_count, left_ff, nxt_left;
    logic [PIPES-1:0] sel_ff, nxt_sel, strobe_ff, nxt_strobe;
    logic addr_hi_ff, nxt_addr_hi, mode_ff, nxt_mode;
    logic ser_d_ff, nxt_ser_d, ser_c_ff, nxt_ser_c;
    logic [HOST_MA_W-1:0] hma_ff, nxt_hma;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, slverr_ff, nxt_slverr;
    logic [1:0] ext_ff, nxt_ext;
    logic ext_wr_ff, nxt_ext_wr, ext_sweep_ff, nxt_ext_sweep;
    logic [SWEEP_W-1:0] swd_ff, nxt_swd;
    logic m1_en_ff, m1_we_ff, m2_en_ff, m2_we_ff;
    logic nxt_m1_en, nxt_m1_we, nxt_m2_en, nxt_m2_we;
    logic [MEM_AW-1:0] m1_a_ff, m2_a_ff, nxt_m1_a, nxt_m2_a;
    logic [WORD_W-1:0] m1_d_ff, m2_d_ff, nxt_m1_d, nxt_m2_d;
    logic cs_ff, nxt_cs, swe_ff, nxt_swe;
    logic setup, is_ext, wr_commit, known, cfg_reg, start_cmd;
    logic f_in_ready, f_out_valid, pop, strobe_now;
    logic [FIFO_W-1:0] f_in, f_out;

    function automatic logic reg_known(input logic [7:0] a);
        reg_known = a == OFS_CTRL || a == OFS_DEST || a == OFS_COUNT || a == OFS_STEP
            || a == OFS_STROBE || a == OFS_SERIAL || a == OFS_SWEEP
            || a == OFS_MEMADDR || a == OFS_MEMDATA;
    endfunction : reg_known

    // pipe 1 or 2 feeds channel 1, pipe 3 or 4 feeds channel 2
    assign f_in = {strobe_ff[3] | strobe_ff[2], strobe_ff[1] | strobe_ff[0],
        adma_widen(strobe_ff[2] ? pipe_sample[23:16] : pipe_sample[31:24]),
        adma_widen(strobe_ff[0] ? pipe_sample[7:0] : pipe_sample[15:8])}; // RULE8 RULE9

    adma_fifo #(
        .W(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(|strobe_ff),
        .in_ready(f_in_ready),
        .in_data(f_in),
        .out_valid(f_out_valid),
        .out_ready(mem_ready && state_ff == ST_TRANSFER),
        .out_data(f_out)
    );

    // apb slave
    always_comb
    begin
        setup = psel && !penable;
        is_ext = paddr == OFS_SWEEP || paddr == OFS_MEMDATA;
        known = reg_known(paddr);
        cfg_reg = paddr != OFS_SERIAL && paddr != OFS_SWEEP;
        wr_commit = psel && penable && pready_ff && pwrite && !slverr_ff;
        nxt_pready = 1'b0;
        nxt_slverr = 1'b0;
        nxt_prdata = prdata_ff;
        nxt_ext = ext_ff;
        nxt_ext_wr = ext_wr_ff;
        nxt_ext_sweep = ext_sweep_ff;
        nxt_swd = swd_ff;
        if (setup)
        begin
            // config and memory locked while transferring
            nxt_slverr = !known || (mode_ff && cfg_reg && (pwrite || paddr == OFS_MEMDATA)); // RULE6 RULE12
            if (is_ext && !nxt_slverr)
            begin
                nxt_ext = EXT_WAIT;
                nxt_ext_wr = pwrite;
                nxt_ext_sweep = paddr == OFS_SWEEP; // RULE15
                nxt_swd = pwdata[SWEEP_W-1:0];
            end
            else
            begin
                nxt_pready = 1'b1;
                unique case (paddr)
                    OFS_CTRL: nxt_prdata = {27'h000_0000, mode_ff, 2'h0, addr_hi_ff, 1'b0};
                    OFS_DEST: nxt_prdata = {16'h0000, dest_ff};
                    OFS_COUNT: nxt_prdata = {16'h0000, count_ff};
                    OFS_STEP: nxt_prdata = {16'h0000, step_ff};
                    OFS_STROBE: nxt_prdata = {28'h000_0000, sel_ff};
                    OFS_SERIAL: nxt_prdata = {29'h0000_0000, serial_data_in, ser_c_ff, ser_d_ff};
                    OFS_MEMADDR: nxt_prdata = {14'h0000, hma_ff};
                    default: nxt_prdata = 32'h0000_0000;
                endcase
            end
        end
        else if (ext_ff != 2'h0)
        begin
            nxt_ext = 2'(ext_ff - 1'b1);
            if (ext_ff == 2'h1)
            begin
                nxt_pready = 1'b1;
                if (ext_sweep_ff)
                    nxt_prdata = {24'h00_0000, sweep_rdata};
                else
                    nxt_prdata = {16'h0000, hma_ff[MA_CHAN_BIT] ? mem2_rdata : mem1_rdata};
            end
        end
        nxt_cs = nxt_ext_sweep && nxt_ext != 2'h0; // RULE15
        nxt_swe = nxt_ext_sweep && nxt_ext_wr && nxt_ext == EXT_WAIT;
    end

    // register updates and transfer sequencing
    always_comb
    begin
        pop = f_out_valid && mem_ready && state_ff == ST_TRANSFER;
        start_cmd = wr_commit && paddr == OFS_CTRL && pwdata[CTRL_START_BIT]
            && state_ff == ST_PROGRAM && count_ff != '0;
        strobe_now = state_ff == ST_TRANSFER && left_ff != '0 && strobe_ff == '0
            && f_in_ready;
        nxt_state = state_ff;
        nxt_dest = dest_ff;
        nxt_count = count_ff;
        nxt_step = step_ff;
        nxt_sel = sel_ff;
        nxt_addr_hi = addr_hi_ff;
        nxt_left = left_ff;
        nxt_ser_d = ser_d_ff;
        nxt_ser_c = ser_c_ff;
        nxt_hma = hma_ff;
        nxt_strobe = strobe_now ? sel_ff : 4'h0; // RULE4 RULE13
        nxt_left = strobe_now ? CNT_W'(left_ff - 1'b1) : left_ff;
        if (wr_commit)
        begin
            unique case (paddr)
                OFS_CTRL: nxt_addr_hi = pwdata[CTRL_ADDRHI_BIT];
                OFS_DEST: nxt_dest = pwdata[ADDR_W-1:0]; // RULE1
                OFS_COUNT: nxt_count = pwdata[CNT_W-1:0]; // RULE2
                OFS_STEP: nxt_step = pwdata[ADDR_W-1:0];
                OFS_STROBE: nxt_sel = pwdata[PIPES-1:0];
                OFS_SERIAL:
                begin
                    nxt_ser_d = pwdata[SER_DATA_BIT]; // RULE14
                    nxt_ser_c = pwdata[SER_CLK_BIT];
                end
                OFS_MEMADDR: nxt_hma = pwdata[HOST_MA_W-1:0];
                default: nxt_hma = hma_ff;
            endcase
        end
        if (start_cmd)
        begin
            nxt_state = ST_TRANSFER; // RULE7
            nxt_left = count_ff; // RULE2
        end
        if (pop)
        begin
            nxt_dest = ADDR_W'(dest_ff + step_ff); // RULE1 RULE3
            nxt_count = CNT_W'(count_ff - 1'b1); // RULE2
            if (count_ff == 16'h0001)
            begin
                nxt_state = ST_PROGRAM; // RULE16
                nxt_strobe = 4'h0;
                nxt_left = 16'h0000;
            end
        end
        nxt_mode = nxt_state == ST_TRANSFER; // RULE5
    end

    // memory ports: engine in transfer mode, host otherwise
    always_comb
    begin
        nxt_m1_en = 1'b0;
        nxt_m2_en = 1'b0;
        nxt_m1_we = 1'b0;
        nxt_m2_we = 1'b0;
        nxt_m1_a = m1_a_ff;
        nxt_m2_a = m2_a_ff;
        nxt_m1_d = m1_d_ff;
        nxt_m2_d = m2_d_ff;
        if (pop)
        begin
            nxt_m1_en = f_out[32]; // RULE10 RULE11
            nxt_m2_en = f_out[33]; // RULE10 RULE11
            nxt_m1_we = f_out[32];
            nxt_m2_we = f_out[33];
            nxt_m1_a = {addr_hi_ff, dest_ff};
            nxt_m2_a = {addr_hi_ff, dest_ff};
            nxt_m1_d = f_out[15:0];
            nxt_m2_d = f_out[31:16];
        end
        else if (setup && paddr == OFS_MEMDATA && !nxt_slverr)
        begin
            nxt_m1_en = !hma_ff[MA_CHAN_BIT]; // RULE12
            nxt_m2_en = hma_ff[MA_CHAN_BIT];
            nxt_m1_we = pwrite && !hma_ff[MA_CHAN_BIT];
            nxt_m2_we = pwrite && hma_ff[MA_CHAN_BIT];
            nxt_m1_a = hma_ff[MEM_AW-1:0];
            nxt_m2_a = hma_ff[MEM_AW-1:0];
            nxt_m1_d = pwdata[WORD_W-1:0];
            nxt_m2_d = pwdata[WORD_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= ST_PROGRAM;
            mode_ff <= 1'b0;
            dest_ff <= RST_DEST;
            count_ff <= RST_COUNT;
            step_ff <= RST_STEP;
            sel_ff <= RST_STROBE;
            addr_hi_ff <= 1'b0;
            left_ff <= RST_COUNT;
            strobe_ff <= 4'h0;
            ser_d_ff <= 1'b0;
            ser_c_ff <= 1'b0;
            hma_ff <= '0;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            slverr_ff <= 1'b0;
            ext_ff <= 2'h0;
            ext_wr_ff <= 1'b0;
            ext_sweep_ff <= 1'b0;
            swd_ff <= '0;
            cs_ff <= 1'b0;
            swe_ff <= 1'b0;
            m1_en_ff <= 1'b0;
            m2_en_ff <= 1'b0;
            m1_we_ff <= 1'b0;
            m2_we_ff <= 1'b0;
            m1_a_ff <= '0;
            m2_a_ff <= '0;
            m1_d_ff <= '0;
            m2_d_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
            dest_ff <= nxt_dest;
            count_ff <= nxt_count;
            step_ff <= nxt_step;
            sel_ff <= nxt_sel;
            addr_hi_ff <= nxt_addr_hi;
            left_ff <= nxt_left;
            strobe_ff <= nxt_strobe;
            ser_d_ff <= nxt_ser_d;
            ser_c_ff <= nxt_ser_c;
            hma_ff <= nxt_hma;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            slverr_ff <= nxt_slverr;
            ext_ff <= nxt_ext;
            ext_wr_ff <= nxt_ext_wr;
            ext_sweep_ff <= nxt_ext_sweep;
            swd_ff <= nxt_swd;
            cs_ff <= nxt_cs;
            swe_ff <= nxt_swe;
            m1_en_ff <= nxt_m1_en;
            m2_en_ff <= nxt_m2_en;
            m1_we_ff <= nxt_m1_we;
            m2_we_ff <= nxt_m2_we;
            m1_a_ff <= nxt_m1_a;
            m2_a_ff <= nxt_m2_a;
            m1_d_ff <= nxt_m1_d;
            m2_d_ff <= nxt_m2_d;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = slverr_ff;
    assign transfer_mode_select = mode_ff;
    assign demux_strobe = strobe_ff;
    assign mem1_en = m1_en_ff;
    assign mem1_we = m1_we_ff;
    assign mem1_addr = m1_a_ff;
    assign mem1_wdata = m1_d_ff;
    assign mem2_en = m2_en_ff;
    assign mem2_we = m2_we_ff;
    assign mem2_addr = m2_a_ff;
    assign mem2_wdata = m2_d_ff;
    assign serial_data = ser_d_ff;
    assign serial_clk = ser_c_ff;
    // chip select held for the two wait cycles of a sweep access
    assign sweep_cs = cs_ff; // RULE15
    assign sweep_we = swe_ff;
    assign sweep_wdata = swd_ff;

    sequence s_start;
        wr_commit && paddr == OFS_CTRL && pwdata[CTRL_START_BIT] && !mode_ff && count_ff != '0;
    endsequence
    sequence s_last_pop;
        pop && count_ff == 16'h0001;
    endsequence

    a_start_raises_mode: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        s_start |=> transfer_mode_select ##1 (|demux_strobe || !f_in_ready || sel_ff == '0))
        else $error("start did not enter transfer mode and strobe");
    a_last_ends_mode: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
        s_last_pop |=> !transfer_mode_select && demux_strobe == 4'h0)
        else $error("transfer did not end at zero count");
    a_step_added: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        pop |=> dest_ff == ADDR_W'($past(dest_ff) + $past(step_ff)))
        else $error("address not advanced by step");
    a_count_down: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        pop |=> count_ff == CNT_W'($past(count_ff) - 1'b1))
        else $error("count not decremented");
    a_strobe_select: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        |demux_strobe |-> demux_strobe == sel_ff && transfer_mode_select)
        else $error("strobe differs from selection or outside transfer");
    a_sample_widened: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        $rose(mem1_en) && mem1_we && $past(pop) |-> mem1_wdata[15:8] == 8'h00)
        else $error("sample not widened");
    a_single_channel: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        pop && sel_ff[3:2] == 2'b00 && f_out[33] == 1'b0 |=> !mem2_en)
        else $error("unselected channel memory written");
    a_host_mem_lock: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        mode_ff && $past(mode_ff) && (mem1_en || mem2_en) |-> $past(pop))
        else $error("host touched memory in transfer mode");
    a_sweep_select: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
        setup && paddr == OFS_SWEEP && !pslverr |=> sweep_cs [*2] ##1 pready)
        else $error("sweep access without chip select");
    a_serial_host: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
        $changed(serial_clk) |-> $past(wr_commit && paddr == OFS_SERIAL))
        else $error("serial clock moved without host write");
    a_dest_source: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        $changed(dest_ff) |-> $past(pop || (wr_commit && paddr == OFS_DEST)))
        else $error("address changed without cause");
endmodule : adma_engine

// file: dv/adma_far_side.sv
`timescale 1ns/1ps
module adma_far_side
    import adma_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic stall, // hold memories busy
    input wire logic [PIPES-1:0] demux_strobe, // strobes in
    output logic [31:0] pipe_sample, // pipe bytes
    input wire logic mem1_en, // ch1 enable
    input wire logic mem1_we, // ch1 write
    input wire logic [MEM_AW-1:0] mem1_addr, // ch1 address
    input wire logic [WORD_W-1:0] mem1_wdata, // ch1 data in
    output logic [WORD_W-1:0] mem1_rdata, // ch1 data out
    input wire logic mem2_en, // ch2 enable
    input wire logic mem2_we, // ch2 write
    input wire logic [MEM_AW-1:0] mem2_addr, // ch2 address
    input wire logic [WORD_W-1:0] mem2_wdata, // ch2 data in
    output logic [WORD_W-1:0] mem2_rdata, // ch2 data out
    output logic mem_ready, // memories free
    input wire logic serial_data, // loop data
    output logic serial_data_in, // loop return
    input wire logic sweep_cs, // sweep select
    input wire logic sweep_we, // sweep write
    input wire logic [SWEEP_W-1:0] sweep_wdata, // sweep data in
    output logic [SWEEP_W-1:0] sweep_rdata // sweep data out
);
    logic [WORD_W-1:0] m1 [0:131071];
    logic [WORD_W-1:0] m2 [0:131071];
    logic [5:0] seq = 6'h00;
    logic [SWEEP_W-1:0] swreg = 8'h00;
    logic [31:0] bytes;
    int w1 = 0;
    int w2 = 0;
    initial mem1_rdata = 16'h0000;
    initial mem2_rdata = 16'h0000;
    assign bytes = {seq, 2'h3, seq, 2'h2, seq, 2'h1, seq, 2'h0};
    // bytes only hold while strobed, otherwise the inverted pattern
    assign pipe_sample = (demux_strobe != 4'h0) ? bytes : ~bytes;
    assign mem_ready = !stall;
    assign serial_data_in = serial_data;
    assign sweep_rdata = sweep_cs ? swreg : ~swreg;
    always @(posedge pclk)
    begin
        if (demux_strobe != 4'h0) seq <= seq + 6'h01;
        if (mem1_en && mem1_we) m1[mem1_addr] <= mem1_wdata;
        if (mem1_en && mem1_we) w1 <= w1 + 1;
        if (mem2_en && mem2_we) m2[mem2_addr] <= mem2_wdata;
        if (mem2_en && mem2_we) w2 <= w2 + 1;
        mem1_rdata <= (mem1_en && !mem1_we) ? m1[mem1_addr] : ~mem1_rdata;
        mem2_rdata <= (mem2_en && !mem2_we) ? m2[mem2_addr] : ~mem2_rdata;
        if (sweep_cs && sweep_we) swreg <= sweep_wdata;
    end
endmodule : adma_far_side

// file: dv/tb_acquisition_dma_engine.sv
`timescale 1ns/1ps
module tb_acquisition_dma_engine
    import adma_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, pipe_sample;
    logic pready, pslverr, er, mode, m1_en, m1_we, m2_en, m2_we, rdy;
    logic ser_d, ser_c, ser_in, sw_cs, sw_we;
    logic [3:0] strobe;
    logic [3:0] exp_sel = 4'h0;
    logic [16:0] m1_a, m2_a;
    logic [15:0] m1_wd, m2_wd, m1_rd, m2_rd;
    logic [7:0] sw_wd, sw_rd;
    logic prev_st = 1'b0;
    int n_fail = 0, cmp_count = 0, ns = 0, cs_cnt = 0, cyc = 0;

    adma_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .transfer_mode_select(mode), .demux_strobe(strobe),
        .pipe_sample(pipe_sample), .mem1_en(m1_en), .mem1_we(m1_we), .mem1_addr(m1_a),
        .mem1_wdata(m1_wd), .mem1_rdata(m1_rd), .mem2_en(m2_en), .mem2_we(m2_we),
        .mem2_addr(m2_a), .mem2_wdata(m2_wd), .mem2_rdata(m2_rd), .mem_ready(rdy),
        .serial_data(ser_d), .serial_clk(ser_c), .serial_data_in(ser_in), .sweep_cs(sw_cs),
        .sweep_we(sw_we), .sweep_wdata(sw_wd), .sweep_rdata(sw_rd));

    adma_far_side p (.pclk(pclk), .stall(stall), .demux_strobe(strobe),
        .pipe_sample(pipe_sample), .mem1_en(m1_en), .mem1_we(m1_we), .mem1_addr(m1_a),
        .mem1_wdata(m1_wd), .mem1_rdata(m1_rd), .mem2_en(m2_en), .mem2_we(m2_we),
        .mem2_addr(m2_a), .mem2_wdata(m2_wd), .mem2_rdata(m2_rd), .mem_ready(rdy),
        .serial_data(ser_d), .serial_data_in(ser_in), .sweep_cs(sw_cs), .sweep_we(sw_we),
        .sweep_wdata(sw_wd), .sweep_rdata(sw_rd));

    initial
    begin
        forever #10 pclk = ~pclk;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, rd, exp);
        chk("slverr", {31'h0, er}, 32'h0000_0000);
    endtask : rdchk

    // strobe watcher: select pattern, never two cycles running
    always @(posedge pclk)
    begin
        cyc++;
        if (strobe !== 4'h0) ns++;
        if (strobe !== 4'h0) chk("strobe", {28'h0, strobe}, {28'h0, exp_sel});
        if (strobe !== 4'h0) chk("gap", {31'h0, prev_st}, 32'h0000_0000);
        prev_st = (strobe !== 4'h0);
        if (sw_cs === 1'b1) cs_cnt++;
        if (cyc == 20000) n_fail++;
        if (cyc == 20000) finish_test();
    end

    task automatic t_reset();
        rdchk("dest", OFS_DEST, {16'h0000, RST_DEST});
        rdchk("count", OFS_COUNT, {16'h0000, RST_COUNT});
        rdchk("step", OFS_STEP, {16'h0000, RST_STEP});
        rdchk("sel", OFS_STROBE, {28'h000_0000, RST_STROBE});
        rdchk("ctrl", OFS_CTRL, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped", {31'h0, er}, 32'h0000_0001);
    endtask : t_reset

    task automatic xfer(input logic [3:0] sel, input logic [15:0] dst, input logic [15:0] stp,
        input logic [15:0] cnt, input int pa, input int pb, input logic stl);
        int k0, w1, w2, n0;
        logic [16:0] a;
        exp_sel = sel;
        apb(1'b1, OFS_DEST, {16'h0000, dst});
        apb(1'b1, OFS_STEP, {16'h0000, stp});
        apb(1'b1, OFS_COUNT, {16'h0000, cnt});
        apb(1'b1, OFS_STROBE, {28'h000_0000, sel});
        k0 = p.seq;
        w1 = p.w1;
        w2 = p.w2;
        n0 = ns;
        stall <= stl;
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        @(posedge pclk);
        chk("mode_on", {31'h0, mode}, 32'h0000_0001);
        if (stl)
        begin
            repeat (60) @(posedge pclk);
            chk("held_writes", p.w1 + p.w2 - w1 - w2, 0);
            chk("held_strobes", ns - n0 < cnt, 1);
            apb(1'b1, OFS_DEST, 32'h0000_0000);
            chk("cfg_locked", {31'h0, er}, 32'h0000_0001);
            apb(1'b0, OFS_MEMDATA, 32'h0000_0000);
            chk("mem_locked", {31'h0, er}, 32'h0000_0001);
            rdchk("ctrl_mode", OFS_CTRL, 32'h0000_0010);
            stall <= 1'b0;
        end
        for (int i = 0; i < 400 && mode !== 1'b0; i++) @(posedge pclk);
        @(posedge pclk);
        chk("mode_off", {31'h0, mode}, 32'h0000_0000);
        chk("strobes", ns - n0, cnt);
        for (int i = 0; i < cnt; i++)
        begin
            a = {1'b0, 16'(dst + i * stp)};
            if (pa >= 0) chk("ch1", {16'h0, p.m1[a]}, {24'h0, 6'(k0 + i), 2'(pa)});
            if (pb >= 0) chk("ch2", {16'h0, p.m2[a]}, {24'h0, 6'(k0 + i), 2'(pb)});
        end
        chk("ch1_writes", p.w1 - w1, pa >= 0 ? cnt : 0);
        chk("ch2_writes", p.w2 - w2, pb >= 0 ? cnt : 0);
        rdchk("count_end", OFS_COUNT, 32'h0000_0000);
        rdchk("dest_end", OFS_DEST, {16'h0000, 16'(dst + cnt * stp)});
    endtask : xfer

    task automatic t_misc();
        int n0, c0;
        n0 = ns;
        apb(1'b1, OFS_COUNT, 32'h0000_0000);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        repeat (4) @(posedge pclk);
        chk("zero_mode", {31'h0, mode}, 32'h0000_0000);
        chk("zero_strobes", ns - n0, 0);
        apb(1'b1, OFS_MEMADDR, 32'h0002_0005);
        apb(1'b1, OFS_MEMDATA, 32'h0000_BEEF);
        chk("mem2_host", {16'h0, p.m2[5]}, 32'h0000_BEEF);
        apb(1'b1, OFS_MEMADDR, 32'h0000_0007);
        apb(1'b1, OFS_MEMDATA, 32'h0000_1234);
        chk("mem1_host", {16'h0, p.m1[7]}, 32'h0000_1234);
        rdchk("mem1_back", OFS_MEMDATA, 32'h0000_1234);
        for (int v = 0; v < 4; v++)
        begin
            apb(1'b1, OFS_SERIAL, 32'(v));
            @(posedge pclk);
            chk("ser_pins", {30'h0, ser_c, ser_d}, 32'(v));
            rdchk("ser_back", OFS_SERIAL, 32'(v) | (32'(v & 1) << 2));
        end
        c0 = cs_cnt;
        apb(1'b1, OFS_SWEEP, 32'h0000_005A);
        chk("sweep_reg", {24'h0, p.swreg}, 32'h0000_005A);
        chk("cs_cycles", cs_cnt - c0, 2);
        rdchk("sweep_rd", OFS_SWEEP, 32'h0000_005A);
    endtask : t_misc

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        xfer(4'b0101, 16'h0010, 16'h0002, 16'h0003, 0, 2, 1'b0);
        xfer(4'b1010, 16'hFFFE, 16'h0001, 16'h0004, 1, 3, 1'b0);
        xfer(4'b0001, 16'h0100, 16'h0003, 16'h0005, 0, -1, 1'b0);
        xfer(4'b1000, 16'h0300, 16'h0001, 16'h0002, -1, 3, 1'b0);
        xfer(4'b0100, 16'h0200, 16'h0001, 16'h000C, -1, 2, 1'b1);
        t_misc();
        finish_test();
    end
endmodule : tb_acquisition_dma_engine
